// ==== design/spie_pkg.sv ====
// Shared constants and carrier types of the serial byte-transfer engine.
// Assumes a single 200 MHz system clock; link pins arrive unsynchronised.
package spie_pkg;

  // ---------------------------------------------------------------
  // Clock and serial timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int SCLK_HALF_NS = 250;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCLK_HALF_CYCLES - 1);
  localparam logic [DIV_W-1:0] DIV_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Transfer shape
  // ---------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int EDGE_W = 4;
  localparam logic [EDGE_W-1:0] EDGE_LAST = 4'hF;
  localparam logic [EDGE_W-1:0] EDGE_RESET = 4'h0;
  localparam int TXQ_DEPTH = 2;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] SLAVE_IDLE_BYTE = 8'hFF;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SP_IDLE, SP_SHIFT, SP_TAIL} spie_state_t;

  typedef struct packed {
    logic master_mode;
    logic clk_polarity;
    logic clk_phase;
    logic lsb_first_enable;
  } spie_cfg_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic ss_n;
  } spie_pins_in_t;

  typedef struct packed {
    logic sclk;
    logic sclk_oe_n;
    logic mosi;
    logic mosi_oe_n;
    logic miso;
    logic miso_oe_n;
    logic ss_n;
    logic ss_n_oe_n;
  } spie_pins_out_t;

endpackage

// ==== design/spie_buf2.sv ====
// Small valid/ready FIFO standing between the software write port and the shifter.
// Assumes both sides run on mclk; push and pop may happen in the same cycle.
`timescale 1ns/10ps
`default_nettype none

module spie_buf2
  import spie_pkg::*;
#(
  parameter int WIDTH = BYTE_W,
  parameter int DEPTH = TXQ_DEPTH
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // ---------------------------------------------------------------
  // Status and head
  // ---------------------------------------------------------------
  assign in_ready = (count_reg != CNT_W'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];

  // Wrap a pointer at the depth
  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
  endfunction

  // Storage, written only on push
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= bump(wr_ptr_reg);
      if (pop) rd_ptr_reg <= bump(rd_ptr_reg);
      if (push && !pop) count_reg <= CNT_W'(count_reg + 1'b1);
      else if (pop && !push) count_reg <= CNT_W'(count_reg - 1'b1);
    end
  end

endmodule

`default_nettype wire

// ==== design/spie_engine.sv ====
// Serial byte-transfer engine: master or slave, four clock formats, either bit order.
// Assumes link pins are asynchronous to mclk; software strobes are mclk-synchronous.
`timescale 1ns/10ps
`default_nettype none

module spie_engine
  import spie_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic block_enable,
  input wire spie_cfg_t cfg,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [BYTE_W-1:0] wr_data,
  input wire logic rd_strobe,
  output logic [BYTE_W-1:0] serial_data_register,
  output logic tx_buffer_empty_flag,
  output logic rx_buffer_full_flag,
  output logic busy,
  input wire spie_pins_in_t pins_in,
  output spie_pins_out_t pins_out
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  spie_pins_in_t sync1_reg;
  spie_pins_in_t sync2_reg;
  logic sclk_prev_reg;
  logic ss_prev_reg;

  // Two flops per pin; only the second stage feeds logic
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync1_reg <= '{sclk: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
      sync2_reg <= '{sclk: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
      sclk_prev_reg <= 1'b0;
      ss_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      sclk_prev_reg <= sync2_reg.sclk;
      ss_prev_reg <= sync2_reg.ss_n;
    end
  end

  wire slave_sel = !sync2_reg.ss_n;
  wire ss_fall = ss_prev_reg && !sync2_reg.ss_n;
  wire sclk_edge = sclk_prev_reg ^ sync2_reg.sclk;

  // ---------------------------------------------------------------
  // Transmit queue
  // ---------------------------------------------------------------
  logic q_valid;
  logic q_pop;
  logic [BYTE_W-1:0] q_data;

  // Any entry count below the depth means the transmit stage has room
  spie_buf2 #(.WIDTH(BYTE_W), .DEPTH(TXQ_DEPTH)) u_txq (
    .mclk(mclk),
    .reset(reset),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(q_valid),
    .out_ready(q_pop),
    .out_data(q_data)
  );
  assign tx_buffer_empty_flag = !q_valid;

  // ---------------------------------------------------------------
  // Serial clock divider
  // ---------------------------------------------------------------
  logic [DIV_W-1:0] div_reg;
  wire half_tick = (div_reg == DIV_LAST);

  // One-cycle pulse every half serial clock period
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      div_reg <= DIV_RESET;
    end else if (half_tick) begin
      div_reg <= DIV_RESET;
    end else begin
      div_reg <= DIV_W'(div_reg + 1'b1);
    end
  end

  // ---------------------------------------------------------------
  // Bit-order helpers
  // ---------------------------------------------------------------
  // Bit that leaves next
  function automatic logic head_bit(input logic [BYTE_W-1:0] v, input logic lsb_first);
    head_bit = lsb_first ? v[0] : v[BYTE_W-1];
  endfunction

  // Shift a byte one place, inserting at the tail end of the chosen order
  function automatic logic [BYTE_W-1:0] shift_in(input logic [BYTE_W-1:0] v,
                                                 input logic b, input logic lsb_first);
    shift_in = lsb_first ? {b, v[BYTE_W-1:1]} : {v[BYTE_W-2:0], b};
  endfunction

  // ---------------------------------------------------------------
  // Control decode
  // ---------------------------------------------------------------
  spie_state_t state_reg;
  spie_state_t state_next;
  logic [EDGE_W-1:0] edge_reg;
  logic [BYTE_W-1:0] tx_shift_reg;
  logic [BYTE_W-1:0] rx_shift_reg;
  logic [BYTE_W-1:0] rx_data_reg;
  logic rx_full_reg;
  logic out_bit_reg;
  logic sclk_reg;
  logic ss_out_reg;

  wire is_master = cfg.master_mode;
  wire in_shift = (state_reg == SP_SHIFT);
  wire link_edge = in_shift && (is_master ? half_tick : (sclk_edge && slave_sel));
  wire in_bit = is_master ? sync2_reg.miso : sync2_reg.mosi;
  // Phase 1 presents on odd edges numbered from one, phase 0 on even ones except the sixteenth
  wire present_edge = link_edge && (cfg.clk_phase ? !edge_reg[0]
                                    : (edge_reg[0] && edge_reg != EDGE_LAST));
  wire sample_edge = link_edge && (cfg.clk_phase ? edge_reg[0] : !edge_reg[0]);
  wire last_edge = link_edge && (edge_reg == EDGE_LAST);
  // Master ends half a period after the sixteenth edge; slave at the edge itself
  wire done = is_master ? (state_reg == SP_TAIL && half_tick) : last_edge;
  wire slave_start = !is_master && slave_sel && (cfg.clk_phase || ss_fall);
  wire master_start = is_master && q_valid && half_tick;
  wire start = block_enable && (state_reg == SP_IDLE || done)
               && (is_master ? master_start : slave_start);
  wire abort = !block_enable || (!is_master && !slave_sel && state_reg != SP_IDLE);
  wire [BYTE_W-1:0] load_byte = q_valid ? q_data : SLAVE_IDLE_BYTE;
  wire [BYTE_W-1:0] rx_final = shift_in(rx_shift_reg, in_bit, cfg.lsb_first_enable);
  // Phase 0 takes its last bit one edge before the end, phase 1 on the last edge itself
  wire [BYTE_W-1:0] rx_whole = cfg.clk_phase ? rx_final : rx_shift_reg;
  wire rx_done_byte = last_edge;

  assign q_pop = start && q_valid;

  // Next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SP_IDLE: if (start) state_next = SP_SHIFT;
      SP_SHIFT: if (last_edge) state_next = is_master ? SP_TAIL : SP_IDLE;
      SP_TAIL: if (done) state_next = start ? SP_SHIFT : SP_IDLE;
    endcase
    if (abort) state_next = SP_IDLE;
    else if (start) state_next = SP_SHIFT;
  end

  // ---------------------------------------------------------------
  // State, edge count and serial clock
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= SP_IDLE;
      edge_reg <= EDGE_RESET;
      sclk_reg <= 1'b0;
      ss_out_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      if (start) edge_reg <= EDGE_RESET;
      else if (link_edge) edge_reg <= EDGE_W'(edge_reg + 1'b1);
      if (start || state_next == SP_IDLE) sclk_reg <= cfg.clk_polarity;
      else if (link_edge && is_master) sclk_reg <= !sclk_reg;
      ss_out_reg <= !(is_master && state_next != SP_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // Shifters
  // ---------------------------------------------------------------
  // Phase 0 shows the first bit at load; phase 1 waits for the first edge
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_shift_reg <= BYTE_RESET;
      rx_shift_reg <= BYTE_RESET;
      out_bit_reg <= 1'b0;
    end else if (start) begin
      if (cfg.clk_phase) begin
        tx_shift_reg <= load_byte;
      end else begin
        out_bit_reg <= head_bit(load_byte, cfg.lsb_first_enable);
        tx_shift_reg <= shift_in(load_byte, 1'b0, cfg.lsb_first_enable);
      end
      rx_shift_reg <= BYTE_RESET;
    end else begin
      if (present_edge) begin
        out_bit_reg <= head_bit(tx_shift_reg, cfg.lsb_first_enable);
        tx_shift_reg <= shift_in(tx_shift_reg, 1'b0, cfg.lsb_first_enable);
      end
      if (sample_edge) rx_shift_reg <= rx_final;
    end
  end

  // ---------------------------------------------------------------
  // Receive stage
  // ---------------------------------------------------------------
  // Capture the finished byte into the stage; a full stage keeps its byte
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_data_reg <= BYTE_RESET;
      rx_full_reg <= 1'b0;
    end else begin
      if (rx_done_byte && !rx_full_reg) begin
        rx_data_reg <= rx_whole;
        rx_full_reg <= 1'b1;
      end else if (rd_strobe) begin
        rx_full_reg <= 1'b0;
      end
    end
  end

  assign serial_data_register = rx_data_reg;
  assign rx_buffer_full_flag = rx_full_reg;
  assign busy = (state_reg != SP_IDLE);

  // ---------------------------------------------------------------
  // Pin drive, enables active low
  // ---------------------------------------------------------------
  assign pins_out.sclk = sclk_reg;
  assign pins_out.sclk_oe_n = !(block_enable && is_master);
  assign pins_out.mosi = out_bit_reg;
  assign pins_out.mosi_oe_n = !(block_enable && is_master);
  assign pins_out.miso = out_bit_reg;
  assign pins_out.miso_oe_n = !(block_enable && !is_master && slave_sel);
  assign pins_out.ss_n = ss_out_reg;
  assign pins_out.ss_n_oe_n = !(block_enable && is_master);

endmodule

`default_nettype wire

// ==== test/spie_peer.sv ====
// Behavioural far-side peer: the slave that answers the engine in master mode.
// Assumes the format inputs stay stable while select is low.
`timescale 1ns/10ps
`default_nettype none
module spie_peer (
  input wire logic ss_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb_first,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte,
  output logic [7:0] rx_cnt
);
  logic [7:0] sh;
  logic [7:0] rx;
  int nb;
  int mb;
  // Put the next outgoing bit on the line, loading a fresh byte every eighth bit
  task drive;
    begin
      if (nb == 0) sh = tx_byte;
      miso = lsb_first ? sh[0] : sh[7];
      sh = lsb_first ? sh >> 1 : sh << 1;
      nb = (nb + 1) % 8;
    end
  endtask
  initial begin
    miso = 1'b1;
    rx_cnt = 8'h00;
    rx_byte = 8'h00;
  end
  // Select edges: first bit for phase 0, inverted level once released
  always @(ss_n) begin
    nb = 0;
    mb = 0;
    if (ss_n) miso = ~miso;
    else if (!cpha) drive();
  end
  // One clock edge samples, the other shifts
  always @(sclk) begin
    if (!ss_n && (((sclk != cpol) ^ cpha) != 1'b0)) begin
      rx = lsb_first ? {mosi, rx[7:1]} : {rx[6:0], mosi};
      mb = mb + 1;
      if (mb == 8) begin
        rx_byte = rx;
        rx_cnt = rx_cnt + 8'h01;
        mb = 0;
      end
    end else if (!ss_n) drive();
  end
endmodule
`default_nettype wire

// ==== test/spie_engine_sva.sv ====
// Port-level timing checks of the serial engine.
// Assumes it is bound onto spie_engine; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module spie_engine_sva
  import spie_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic block_enable,
  input wire spie_cfg_t cfg,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [BYTE_W-1:0] wr_data,
  input wire logic rd_strobe,
  input wire logic [BYTE_W-1:0] serial_data_register,
  input wire logic tx_buffer_empty_flag,
  input wire logic rx_buffer_full_flag,
  input wire logic busy,
  input wire spie_pins_in_t pins_in,
  input wire spie_pins_out_t pins_out
);
  logic [DIV_W-1:0] gap_reg;
  logic sclk_q_reg;
  wire moved = pins_out.sclk ^ sclk_q_reg;
  // Cycles since the serial clock output last moved, saturating
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      gap_reg <= 8'hFF;
      sclk_q_reg <= 1'b0;
    end else begin
      sclk_q_reg <= pins_out.sclk;
      gap_reg <= moved ? 8'h00 : gap_reg + {7'h00, gap_reg != 8'hFF};
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_rx_read_clear: assert property (rd_strobe && rx_buffer_full_flag |=> !rx_buffer_full_flag)
    else $error("receive flag survived a read");
  a_tx_write_clear: assert property (wr_valid && wr_ready |=> !tx_buffer_empty_flag)
    else $error("transmit flag survived a write");
  a_overrun_keep: assert property (rx_buffer_full_flag && !rd_strobe |=>
    rx_buffer_full_flag && $stable(serial_data_register))
    else $error("held byte changed while unread");
  a_rx_set_busy: assert property ($rose(rx_buffer_full_flag) |-> $past(busy))
    else $error("receive flag rose outside a transfer");
  a_sel_during_xfer: assert property (cfg.master_mode && busy && $past(busy) && $past(busy, 2)
    |-> !pins_out.ss_n)
    else $error("select high during a transfer");
  a_sclk_idle: assert property (cfg.master_mode && !busy && !$past(busy) && $stable(cfg)
    && !$past(reset) |-> pins_out.sclk == cfg.clk_polarity)
    else $error("idle serial clock not at polarity");
  a_sclk_gap: assert property (moved && cfg.master_mode |-> gap_reg >= DIV_LAST)
    else $error("serial clock half period too short");
  a_ready_empty: assert property (tx_buffer_empty_flag |-> wr_ready)
    else $error("empty queue refused a byte");
  a_slave_release: assert property (!cfg.master_mode && pins_in.ss_n [*4] |-> pins_out.miso_oe_n)
    else $error("slave drove its output while deselected");
endmodule
bind spie_engine spie_engine_sva spie_engine_sva_inst (.mclk(mclk), .reset(reset),
  .block_enable(block_enable), .cfg(cfg), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .wr_data(wr_data), .rd_strobe(rd_strobe), .serial_data_register(serial_data_register),
  .tx_buffer_empty_flag(tx_buffer_empty_flag), .rx_buffer_full_flag(rx_buffer_full_flag),
  .busy(busy), .pins_in(pins_in), .pins_out(pins_out));
`default_nettype wire

// ==== test/test_spi_byte_transfer_engine.sv ====
// Self-checking bench of the serial engine in master and slave modes.
// Assumes the peer model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module test_spi_byte_transfer_engine
  import spie_pkg::*;
;
  logic mclk, reset, block_enable, wr_valid, rd_strobe, s_sclk, s_mosi, s_ss_n;
  logic wr_ready, tx_flag, rx_flag, busy, w_miso, peer_miso;
  logic [7:0] wr_data, peer_tx, sdr, peer_rx, peer_cnt, got;
  spie_cfg_t cfg;
  spie_pins_in_t pins_in;
  spie_pins_out_t pins_out;
  int fails, check_count, cyc;
  // Wire levels from the engine's enables
  assign w_miso = pins_out.miso_oe_n ? peer_miso : pins_out.miso;
  assign pins_in = '{sclk: pins_out.sclk_oe_n ? s_sclk : pins_out.sclk,
    mosi: pins_out.mosi_oe_n ? s_mosi : pins_out.mosi, miso: w_miso,
    ss_n: pins_out.ss_n_oe_n ? s_ss_n : pins_out.ss_n};
  spie_engine spie_engine_inst (.mclk(mclk), .reset(reset), .block_enable(block_enable),
    .cfg(cfg), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_strobe(rd_strobe), .serial_data_register(sdr), .tx_buffer_empty_flag(tx_flag),
    .rx_buffer_full_flag(rx_flag), .busy(busy), .pins_in(pins_in), .pins_out(pins_out));
  spie_peer spie_peer_inst (.ss_n(pins_in.ss_n), .sclk(pins_in.sclk), .mosi(pins_in.mosi),
    .cpol(cfg.clk_polarity), .cpha(cfg.clk_phase), .lsb_first(cfg.lsb_first_enable),
    .tx_byte(peer_tx), .miso(peer_miso), .rx_byte(peer_rx), .rx_cnt(peer_cnt));
  task end_of_test;
    begin
      if (fails == 0 && check_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task write_byte(input logic [7:0] d);
    begin
      @(negedge mclk);
      wr_data = d;
      wr_valid = 1'b1;
      while (wr_ready !== 1'b1) @(negedge mclk);
      @(negedge mclk);
      wr_valid = 1'b0;
    end
  endtask
  task read_byte;
    begin
      rd_strobe = 1'b1;
      @(negedge mclk);
      rd_strobe = 1'b0;
    end
  endtask
  task wait_idle;
    int i;
    for (i = 0; i < 4000 && (busy !== 1'b0 || tx_flag !== 1'b1); i++) @(negedge mclk);
    if (i == 4000) begin
      fails++;
      end_of_test();
    end
  endtask
  task wait_cnt(input logic [7:0] n);
    int i;
    for (i = 0; i < 2000 && peer_cnt !== n; i++) @(negedge mclk);
    if (i == 2000) begin
      fails++;
      end_of_test();
    end
  endtask
  // Every clock format in both bit orders, one master byte each
  task t_formats;
    int f;
    for (f = 0; f < 8; f++) begin
      cfg = spie_cfg_t'({1'b1, 3'(f)});
      peer_tx = 8'hA1 + 8'(f);
      wait_idle();
      write_byte(8'hC5 ^ 8'(f));
      `CHK(tx_flag, 1'b0)
      wait_idle();
      `CHK(tx_flag, 1'b1)
      `CHK(peer_rx, 8'hC5 ^ 8'(f))
      `CHK(sdr, 8'hA1 + 8'(f))
      `CHK(rx_flag, 1'b1)
      read_byte();
      `CHK(rx_flag, 1'b0)
    end
  endtask
  // Three queued bytes in a row, never read until the end
  task t_back2back;
    logic [7:0] c0;
    begin
      cfg = 4'hA;
      peer_tx = 8'h96;
      c0 = peer_cnt;
      write_byte(8'h11);
      write_byte(8'h22);
      write_byte(8'h33);
      `CHK(wr_ready, 1'b0)
      wait_cnt(c0 + 8'h01);
      peer_tx = 8'h69;
      `CHK(peer_rx, 8'h11)
      wait_cnt(c0 + 8'h02);
      `CHK(peer_rx, 8'h22)
      wait_idle();
      `CHK(peer_rx, 8'h33)
      `CHK(sdr, 8'h96)
      `CHK(rx_flag, 1'b1)
      read_byte();
    end
  endtask
  // Bench as outside master at four times the link rate; ph is the clock phase, rel frees select after
  task s_xfer(input logic [7:0] b, input logic ph, input logic rel);
    int i;
    begin
      #1.25 s_ss_n = 1'b0;
      for (i = 7; i >= 0; i--) begin
        if (!ph) s_mosi = b[i];
        #62.5 s_sclk = 1'b1;
        if (ph) s_mosi = b[i];
        else got = {got[6:0], w_miso};
        #62.5 s_sclk = 1'b0;
        if (ph) got = {got[6:0], w_miso};
      end
      if (rel) begin
        #62.5 s_ss_n = 1'b1;
        s_mosi = ~s_mosi;
      end
      repeat (10) @(negedge mclk);
    end
  endtask
  task t_slave;
    begin
      cfg = 4'h0;
      write_byte(8'hD2);
      s_xfer(8'h4B, 1'b0, 1'b1);
      `CHK(got, 8'hD2)
      `CHK(sdr, 8'h4B)
      s_xfer(8'h77, 1'b0, 1'b1);
      `CHK(got, SLAVE_IDLE_BYTE)
      `CHK(sdr, 8'h4B)
      // Phase 1 with select held low across two queued bytes
      read_byte();
      cfg = 4'h2;
      write_byte(8'hA5);
      write_byte(8'h3C);
      s_xfer(8'h5A, 1'b1, 1'b0);
      `CHK(got, 8'hA5)
      `CHK(sdr, 8'h5A)
      read_byte();
      s_xfer(8'hC3, 1'b1, 1'b1);
      `CHK(got, 8'h3C)
      `CHK(sdr, 8'hC3)
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    {reset, block_enable, wr_valid, rd_strobe, s_sclk, s_mosi, s_ss_n} = 7'h61;
    {cfg, wr_data, peer_tx, got} = 28'h8000000;
    repeat (4) @(negedge mclk);
    reset = 1'b0;
    t_formats();
    t_back2back();
    t_slave();
    end_of_test();
  end
endmodule
`default_nettype wire
